// File: hw/tpu_map.vh
// offsets, field positions, reset values and rate limits of the test pattern unit
`ifndef TPU_MAP_VH
`define TPU_MAP_VH
`define TPU_CHANNELS     8
`define TPU_OFS_CTRL     7'h60
`define TPU_OFS_STAT     7'h61
`define TPU_OFS_LEN      7'h62
`define TPU_OFS_TAP      7'h63
`define TPU_OFS_ERR      7'h64
`define TPU_OFS_SEED0    7'h68
`define TPU_OFS_SEED1    7'h69
`define TPU_OFS_SEED2    7'h6A
`define TPU_OFS_SEED3    7'h6B
`define TPU_OFS_RB0      7'h6C
`define TPU_OFS_RB1      7'h6D
`define TPU_OFS_RB2      7'h6E
`define TPU_OFS_RB3      7'h6F
`define TPU_CTRL_SEL_HI  7
`define TPU_CTRL_SEL_LO  6
`define TPU_CTRL_TYPE    4
`define TPU_STAT_XFER    1
`define TPU_STAT_OVR     0
`define TPU_ERR_EVENT    3
`define TPU_FIELD_MSB    4
`define TPU_RATE_MSB     2
`define TPU_SEL_ERR      2'h2
`define TPU_SEL_BITS     2'h3
`define TPU_RATE_NONE    3'h0
`define TPU_RST_BYTE     8'h00
`define TPU_RST_FIELD    5'h00
`define TPU_RST_WORD     32'h0000_0000
`define TPU_SAT_WORD     32'hFFFF_FFFF
`define TPU_RST_CNT      24'h00_0000
`define TPU_FIRST_IDX    5'h1F
`define TPU_FILL_DONE    6'h20
`define TPU_RATE_1       24'h00_000A
`define TPU_RATE_2       24'h00_0064
`define TPU_RATE_3       24'h00_03E8
`define TPU_RATE_4       24'h00_2710
`define TPU_RATE_5       24'h01_86A0
`define TPU_RATE_6       24'h0F_4240
`define TPU_RATE_7       24'h98_9680
`endif

// File: hw/tpu_prbs_regs.v
// eight-channel test pattern generator and detector with byte register port
//
// Chosen here: the plain strobed port.
`include "tpu_map.vh"
module tpu_prbs_regs (
   input  wire        mclk,
   input  wire        rst_n,
   input  wire [9:0]  addr,
   input  wire [7:0]  wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [7:0]  rdata,
   input  wire        accum_strobe,
   input  wire [7:0]  tx_bit_en,
   output wire [7:0]  tx_data,
   input  wire [7:0]  rx_bit_en,
   input  wire [7:0]  rx_data
);

   wire [2:0]  ch_sel;
   wire [6:0]  ofs;
   wire [63:0] rd_bus;

   assign ch_sel = addr[9:7];
   assign ofs    = addr[6:0];

   function is_rb;
      input [6:0] o;
      begin
         is_rb = (o >= `TPU_OFS_RB0) && (o <= `TPU_OFS_RB3);
      end
   endfunction

   function [23:0] rate_limit;
      input [2:0] r;
      begin
         case (r)
            3'h1: begin
               rate_limit = `TPU_RATE_1;
            end
            3'h2: begin
               rate_limit = `TPU_RATE_2;
            end
            3'h3: begin
               rate_limit = `TPU_RATE_3;
            end
            3'h4: begin
               rate_limit = `TPU_RATE_4;
            end
            3'h5: begin
               rate_limit = `TPU_RATE_5;
            end
            3'h6: begin
               rate_limit = `TPU_RATE_6;
            end
            3'h7: begin
               rate_limit = `TPU_RATE_7;
            end
            // code 000 never compares, so its limit is a don't-care
            default: begin
               rate_limit = `TPU_RST_CNT;
            end
         endcase
      end
   endfunction

   function [31:0] sat_inc;
      input [31:0] v;
      begin
         sat_inc = (v == `TPU_SAT_WORD) ? v : v + 32'h0000_0001;
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < `TPU_CHANNELS; g = g + 1) begin : chan
         reg        pat_type;
         reg [1:0]  rb_sel;
         reg [4:0]  len_f;
         reg [4:0]  tap_f;
         reg        event_bit;
         reg [2:0]  rate_wr;
         reg [2:0]  rate_act;
         reg [31:0] seed;
         reg        load_q;
         reg [31:0] gen_sr;
         reg [4:0]  rep_idx;
         reg        err_pend;
         reg [23:0] rate_cnt;
         reg        tx_q;
         reg [31:0] rx_sr;
         reg [5:0]  fill;
         reg [31:0] err_cnt;
         reg [31:0] bit_cnt;
         reg [31:0] hold_pat;
         reg [31:0] hold_err;
         reg [31:0] hold_bits;
         reg        done_f;
         reg        ovr_f;
         reg [7:0]  rd_val;
         reg [31:0] rb_word;
         wire       hit;
         wire       wr_hit;
         wire       rd_stat;
         wire       xfer;
         wire       ev_rise;
         wire       rate_hit;
         wire       fb;
         wire       pat_bit;
         wire       ev_use;
         wire       rx_exp;
         wire       rx_err;

         assign hit     = (ch_sel == g);
         assign wr_hit  = wr & hit;
         assign rd_stat = rd & hit & (ofs == `TPU_OFS_STAT);
         assign xfer    = (wr_hit & is_rb(ofs)) | accum_strobe;
         assign ev_rise = wr_hit & (ofs == `TPU_OFS_ERR) & wdata[`TPU_ERR_EVENT] & ~event_bit;
         // feedback taps index the shift history, so field+1 is the bit age
         assign fb      = gen_sr[len_f] ^ gen_sr[tap_f];
         assign pat_bit = pat_type ? gen_sr[rep_idx] : fb;
         assign rate_hit = (rate_act != `TPU_RATE_NONE) &&
                           (rate_cnt == rate_limit(rate_act) - 24'h00_0001);
         assign ev_use  = tx_bit_en[g] & err_pend;
         assign rx_exp  = pat_type ? rx_sr[len_f] : (rx_sr[len_f] ^ rx_sr[tap_f]);
         assign rx_err  = rx_bit_en[g] & (fill == `TPU_FILL_DONE) & (rx_data[g] != rx_exp);
         assign tx_data[g] = tx_q;

         // configuration registers; unused bits are simply not stored
         always @(posedge mclk) begin
            if (!rst_n) begin
               pat_type  <= 1'b0;
               rb_sel    <= 2'h0;
               len_f     <= `TPU_RST_FIELD;
               tap_f     <= `TPU_RST_FIELD;
               event_bit <= 1'b0;
               rate_wr   <= `TPU_RATE_NONE;
               seed      <= `TPU_RST_WORD;
               load_q    <= 1'b0;
            end else begin
               load_q <= wr_hit & (ofs == `TPU_OFS_SEED3);
               if (wr_hit) begin
                  case (ofs)
                     `TPU_OFS_CTRL: begin
                        pat_type <= wdata[`TPU_CTRL_TYPE];
                        rb_sel   <= wdata[`TPU_CTRL_SEL_HI:`TPU_CTRL_SEL_LO];
                     end
                     `TPU_OFS_LEN: begin
                        len_f <= wdata[`TPU_FIELD_MSB:0];
                     end
                     `TPU_OFS_TAP: begin
                        tap_f <= wdata[`TPU_FIELD_MSB:0];
                     end
                     `TPU_OFS_ERR: begin
                        event_bit <= wdata[`TPU_ERR_EVENT];
                        rate_wr   <= wdata[`TPU_RATE_MSB:0];
                     end
                     `TPU_OFS_SEED0: begin
                        seed[7:0] <= wdata;
                     end
                     `TPU_OFS_SEED1: begin
                        seed[15:8] <= wdata;
                     end
                     `TPU_OFS_SEED2: begin
                        seed[23:16] <= wdata;
                     end
                     // top byte also requests the generator load above
                     `TPU_OFS_SEED3: begin
                        seed[31:24] <= wdata;
                     end
                     default: ;
                  endcase
               end
            end
         end

         // generator: the seed is copied once per start so later byte writes
         // cannot disturb a running repetitive pattern
         always @(posedge mclk) begin
            if (!rst_n) begin
               gen_sr  <= `TPU_RST_WORD;
               rep_idx <= `TPU_FIRST_IDX;
               tx_q    <= 1'b0;
            end else if (load_q) begin
               gen_sr  <= seed;
               rep_idx <= `TPU_FIRST_IDX;
            end else if (tx_bit_en[g]) begin
               tx_q <= pat_bit ^ err_pend ^ rate_hit;
               if (pat_type) begin
                  rep_idx <= (rep_idx == `TPU_RST_FIELD) ? len_f : rep_idx - 5'h01;
               end else begin
                  gen_sr <= {gen_sr[30:0], fb};
               end
            end
         end

         // single error: set wins over consumption in the same cycle
         always @(posedge mclk) begin
            if (!rst_n) begin
               err_pend <= 1'b0;
            end else begin
               err_pend <= ev_rise | (err_pend & ~ev_use);
            end
         end

         // rate errors: the active code only changes when an error fires;
         // from idle there is no error to wait for, so it starts at once
         always @(posedge mclk) begin
            if (!rst_n) begin
               rate_act <= `TPU_RATE_NONE;
               rate_cnt <= `TPU_RST_CNT;
            end else if (rate_act == `TPU_RATE_NONE) begin
               rate_act <= rate_wr;
               rate_cnt <= `TPU_RST_CNT;
            end else if (tx_bit_en[g]) begin
               if (rate_hit) begin
                  rate_act <= rate_wr;
                  rate_cnt <= `TPU_RST_CNT;
               end else begin
                  rate_cnt <= rate_cnt + 24'h00_0001;
               end
            end
         end

         // detector: self-synchronising check against the received history
         always @(posedge mclk) begin
            if (!rst_n) begin
               rx_sr   <= `TPU_RST_WORD;
               fill    <= 6'h00;
               err_cnt <= `TPU_RST_WORD;
               bit_cnt <= `TPU_RST_WORD;
            end else begin
               if (rx_bit_en[g]) begin
                  rx_sr <= {rx_sr[30:0], rx_data[g]};
                  if (fill != `TPU_FILL_DONE) begin
                     fill <= fill + 6'h01;
                  end
               end
               if (xfer) begin
                  // the bit arriving with the transfer opens the new interval
                  err_cnt <= {31'h0000_0000, rx_err};
                  bit_cnt <= {31'h0000_0000, rx_bit_en[g]};
               end else begin
                  if (rx_err) begin
                     err_cnt <= sat_inc(err_cnt);
                  end
                  if (rx_bit_en[g]) begin
                     bit_cnt <= sat_inc(bit_cnt);
                  end
               end
            end
         end

         // holding registers and transfer status
         always @(posedge mclk) begin
            if (!rst_n) begin
               hold_pat  <= `TPU_RST_WORD;
               hold_err  <= `TPU_RST_WORD;
               hold_bits <= `TPU_RST_WORD;
               done_f    <= 1'b0;
               ovr_f     <= 1'b0;
            end else begin
               if (xfer) begin
                  hold_pat  <= rx_sr;
                  hold_err  <= err_cnt;
                  hold_bits <= bit_cnt;
               end
               // a transfer in the read cycle survives the clear
               done_f <= xfer | (done_f & ~rd_stat);
               ovr_f  <= (xfer & done_f & ~rd_stat) | (ovr_f & ~rd_stat);
            end
         end

         always @* begin
            case (rb_sel)
               `TPU_SEL_ERR: begin
                  rb_word = hold_err;
               end
               `TPU_SEL_BITS: begin
                  rb_word = hold_bits;
               end
               default: begin
                  rb_word = hold_pat;
               end
            endcase
         end

         always @* begin
            case (ofs)
               `TPU_OFS_CTRL: begin
                  rd_val = {rb_sel, 1'b0, pat_type, 4'h0};
               end
               `TPU_OFS_STAT: begin
                  rd_val = {6'h00, done_f, ovr_f};
               end
               `TPU_OFS_LEN: begin
                  rd_val = {3'h0, len_f};
               end
               `TPU_OFS_TAP: begin
                  rd_val = {3'h0, tap_f};
               end
               // the written rate shows here, not the one still in force
               `TPU_OFS_ERR: begin
                  rd_val = {4'h0, event_bit, rate_wr};
               end
               `TPU_OFS_SEED0: begin
                  rd_val = seed[7:0];
               end
               `TPU_OFS_SEED1: begin
                  rd_val = seed[15:8];
               end
               `TPU_OFS_SEED2: begin
                  rd_val = seed[23:16];
               end
               `TPU_OFS_SEED3: begin
                  rd_val = seed[31:24];
               end
               `TPU_OFS_RB0: begin
                  rd_val = rb_word[7:0];
               end
               `TPU_OFS_RB1: begin
                  rd_val = rb_word[15:8];
               end
               `TPU_OFS_RB2: begin
                  rd_val = rb_word[23:16];
               end
               `TPU_OFS_RB3: begin
                  rd_val = rb_word[31:24];
               end
               default: begin
                  rd_val = `TPU_RST_BYTE;
               end
            endcase
         end

         assign rd_bus[g*8 +: 8] = rd_val;
      end
   endgenerate

   // read data stand only in the cycle after the strobe
   always @(posedge mclk) begin
      if (!rst_n) begin
         rdata <= `TPU_RST_BYTE;
      end else if (rd) begin
         rdata <= rd_bus[{ch_sel, 3'h0} +: 8];
      end else begin
         rdata <= `TPU_RST_BYTE;
      end
   end

endmodule

// File: dv/tpu_prbs_regs_properties.sv
// checker on the test pattern unit ports
module tpu_prbs_regs_properties (
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic [9:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       accum_strobe,
   input wire logic [7:0] tx_bit_en,
   input wire logic [7:0] tx_data,
   input wire logic [7:0] rx_bit_en,
   input wire logic [7:0] rx_data
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire stat_rd = rd && addr[6:0] == 7'h61;
   chk_rdata_idle:
   assert property (!rd |=> rdata == 8'h00) else $error("rdata not idle");
   chk_unmapped_zero:
   assert property (rd && addr[6:0] == 7'h65 |=> rdata == 8'h00) else $error("unmapped read");
   chk_status_unused:
   assert property (stat_rd |=> rdata[7:2] == 6'h00) else $error("status unused bits");
   chk_status_clear:
   assert property ((stat_rd && !accum_strobe) ##1 (stat_rd && $stable(addr) && !accum_strobe)
      |=> rdata[1:0] == 2'h0) else $error("flags kept after read");
   chk_seed_store:
   assert property ((wr && addr[6:2] == 5'h1A) ##1 (rd && $stable(addr)) |=> rdata == $past(wdata, 2))
      else $error("seed byte lost");
   chk_field_store:
   assert property ((wr && addr[6:1] == 6'h31) ##1 (rd && $stable(addr))
      |=> rdata == ($past(wdata, 2) & 8'h1F)) else $error("field lost");
   chk_err_store:
   assert property ((wr && addr[6:0] == 7'h64) ##1 (rd && $stable(addr))
      |=> rdata == ($past(wdata, 2) & 8'h0F)) else $error("insertion ctrl lost");
   chk_tx_hold:
   assert property (((tx_data ^ $past(tx_data)) & ~$past(tx_bit_en)) == 8'h00) else $error("tx moved");
   chk_xfer_set:
   assert property (accum_strobe ##1 !rd ##1 stat_rd |=> rdata[1] == 1'b1) else $error("no transfer flag");
endmodule
bind tpu_prbs_regs tpu_prbs_regs_properties u_chk (.mclk(mclk), .rst_n(rst_n), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .accum_strobe(accum_strobe), .tx_bit_en(tx_bit_en),
   .tx_data(tx_data), .rx_bit_en(rx_bit_en), .rx_data(rx_data));

// File: dv/tpu_framer_model.sv
// framer model: paces transmit bits and loops them back as receive bits
module tpu_framer_model (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [3:0] pace,
   input  wire logic [7:0] tx_data,
   output logic      [7:0] tx_bit_en,
   output logic      [7:0] rx_bit_en,
   output logic      [7:0] rx_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   logic [7:0] pend;
   always @(posedge mclk) begin
      cnt <= (pace == 4'h0 || cnt == pace - 4'h1) ? 4'h0 : cnt + 4'h1;
      tx_bit_en <= (pace != 4'h0 && cnt == 4'h0) ? 8'hFF : 8'h00;
      pend <= tx_bit_en;
      rx_bit_en <= pend;
      // idle line inverts its own value every cycle so stale data never looks valid
      rx_data <= (pend & tx_data) | (~pend & ~rx_data);
      if (!rst_n) begin
         tx_bit_en <= 8'h00;
         pend <= 8'h00;
         rx_bit_en <= 8'h00;
         rx_data <= 8'h00;
      end
   end
endmodule

// File: dv/test_tpu_prbs_regs.sv
// self-checking bench for the test pattern unit
module test_tpu_prbs_regs;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] seed_val = 32'hA5C3_6666;
   logic       mclk = 1'b0;
   logic       rst_n = 1'b0;
   logic [9:0] addr = 10'h000;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic       accum_strobe = 1'b0;
   logic [3:0] pace = 4'h0;
   logic       en_d = 1'b0;
   wire  [7:0] rdata, tx_bit_en, tx_data, rx_bit_en, rx_data;
   int         err_count = 0;
   int         check_count = 0;
   int         cyc = 0;
   logic       bits[$];
   always #25 mclk = ~mclk;
   tpu_prbs_regs u_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .accum_strobe(accum_strobe), .tx_bit_en(tx_bit_en), .tx_data(tx_data),
      .rx_bit_en(rx_bit_en), .rx_data(rx_data));
   tpu_framer_model u_far (.mclk(mclk), .rst_n(rst_n), .pace(pace), .tx_data(tx_data),
      .tx_bit_en(tx_bit_en), .rx_bit_en(rx_bit_en), .rx_data(rx_data));
   // channel 0 transmit bits, captured the cycle after their enable
   always @(posedge mclk) begin
      if (en_d)
         bits.push_back(tx_data[0]);
      en_d <= tx_bit_en[0];
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // bus tasks are entered just after a clock edge
   task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [9:0] a, input logic [7:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk({24'h00_0000, rdata}, {24'h00_0000, exp});
   endtask
   task automatic rd_word(input logic [9:0] a, input logic [31:0] exp);
      for (int k = 0; k < 4; k++)
         rd_reg(a + k[9:0], exp[8*k +: 8]);
   endtask
   task automatic pulse();
      accum_strobe <= 1'b1;
      @(posedge mclk);
      accum_strobe <= 1'b0;
      @(posedge mclk);
      #1;
   endtask
   task automatic run(input int n);
      int s;
      s = bits.size();
      pace <= 4'h1;
      while (bits.size() < s + n)
         @(posedge mclk);
      pace <= 4'h0;
      repeat (8) @(posedge mclk);
      #1;
   endtask
   // mismatches against seed bits 31..0 then the four-bit loop
   function automatic int nerr(input int a, input int b);
      nerr = 0;
      for (int i = a; i < b; i++)
         nerr += int'(bits[i] !== (i < 32 ? seed_val[31 - i] : seed_val[3 - (i - 32) % 4]));
   endfunction
   task automatic t_reset();
      for (int c = 0; c < 8; c += 7)
         for (int o = 8; o < 16; o++)
            rd_reg({c[2:0], 3'h6, o[3:0]}, 8'h00);
   endtask
   task automatic t_regs();
      for (int c = 0; c < 8; c++) begin
         wr_reg({c[2:0], 7'h62}, 8'hE0 | c[7:0]);
         rd_reg({c[2:0], 7'h62}, c[7:0]);
         wr_reg({c[2:0], 7'h63}, ~c[7:0]);
         rd_reg({c[2:0], 7'h63}, ~c[7:0] & 8'h1F);
         rd_reg({c[2:0], 7'h65}, 8'h00);
      end
   endtask
   task automatic t_flags();
      wr_reg(10'h06C, 8'hA5);
      rd_reg(10'h06C, 8'h00);
      rd_reg(10'h061, 8'h02);
      rd_reg(10'h061, 8'h00);
      pulse();
      pulse();
      rd_reg(10'h061, 8'h03);
      rd_reg(10'h061, 8'h00);
      rd_reg(10'h0E1, 8'h03);
   endtask
   task automatic t_stream();
      logic [31:0] w;
      wr_reg(10'h060, 8'h10);
      wr_reg(10'h062, 8'h03);
      for (int k = 0; k < 4; k++) begin
         wr_reg(10'h068 + k[9:0], seed_val[8*k +: 8]);
         rd_reg(10'h068 + k[9:0], seed_val[8*k +: 8]);
      end
      repeat (3) @(posedge mclk);
      #1 bits.delete();
      pulse();
      run(40);
      chk(nerr(0, 40), 0);
      for (int k = 0; k < 32; k++)
         w[k] = bits[bits.size() - 1 - k];
      wr_reg(10'h06F, 8'h00);
      rd_word(10'h06C, w);
      wr_reg(10'h060, 8'h90);
      rd_word(10'h06C, 32'h0000_0000);
      wr_reg(10'h060, 8'hD0);
      rd_word(10'h06C, bits.size());
      wr_reg(10'h060, 8'h50);
      rd_word(10'h06C, w);
   endtask
   task automatic t_event();
      int s;
      s = bits.size();
      wr_reg(10'h064, 8'h08);
      rd_reg(10'h064, 8'h08);
      run(20);
      wr_reg(10'h064, 8'h08);
      run(20);
      chk(nerr(s, bits.size()), 1);
      wr_reg(10'h064, 8'h01);
      s = bits.size();
      run(100);
      chk(nerr(s, s + 100), 10);
      s = bits.size();
      wr_reg(10'h064, 8'h00);
      run(40);
      chk(nerr(s, bits.size()), 1);
      wr_reg(10'h064, 8'h02);
      s = bits.size();
      run(200);
      chk(nerr(s, s + 200), 2);
   endtask
   task automatic t_prbs();
      logic [31:0] sr;
      logic        nb;
      sr = 32'hFFFF_FFFF;
      wr_reg(10'h060, 8'h00);
      wr_reg(10'h062, 8'h04);
      wr_reg(10'h063, 8'h02);
      for (int k = 0; k < 4; k++)
         wr_reg(10'h068 + k[9:0], 8'hFF);
      repeat (3) @(posedge mclk);
      #1 bits.delete();
      run(30);
      for (int i = 0; i < 30; i++) begin
         nb = sr[4] ^ sr[2];
         sr = {sr[30:0], nb};
         chk({31'h0, bits[i]}, {31'h0, nb});
      end
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      #1;
      t_reset();
      t_regs();
      t_flags();
      t_stream();
      t_event();
      t_prbs();
      give_verdict();
   end
endmodule
